/* File: design/dss_regs.svh */
// Purpose: Constants for drive start and set select block
// Assumes: 200 MHz reference clock
// Notes:   Timing counts derive from times in their own units
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH
`define DSS_CLK_MHZ        200
`define DSS_PULSE_MIN_MS   32
`define DSS_PULSE_MIN_CYC  (`DSS_PULSE_MIN_MS * 1000 * `DSS_CLK_MHZ)
`define DSS_LR_3W_CONTACT  8'h05
`define DSS_LR_3W_KEYPAD   8'h2E
`define DSS_SEL_RESET      2'h0
`endif

/* File: design/dss_pkg.sv */
// Purpose: Types for drive start and set select block
// Assumes: Nothing beyond the constants header
// Notes:   Structs group related control bits
package dss_pkg;
	typedef struct packed {
		logic first;
		logic second;
	} dss_sel_t;

	typedef struct packed {
		logic run_cw;
		logic run_ccw;
		logic stop;
	} dss_drive_t;

	typedef enum logic [2:0] {
		DSS_IDLE  = 3'b001,
		DSS_CHECK = 3'b010,
		DSS_RUN   = 3'b100
	} dss_state_t;
endpackage : dss_pkg

/* File: design/dss_sync.sv */
// Purpose: Two-flop synchroniser for a bundle of pin inputs
// Assumes: Inputs asynchronous to ref_clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module dss_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_reg <= '0;
			q_o      <= '0;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule : dss_sync

/* File: design/dss_decode.sv */
// Purpose: Two-bit select decoder for set and fixed-value choice
// Assumes: Inputs already synchronised
// Notes:   Output index 0..3 stands for choice 1..4
`timescale 1ns/1ps
`include "dss_regs.svh"
module dss_decode (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_b_i,
	input  wire dss_pkg::dss_sel_t sel_i,
	output logic      [1:0]        idx_o
);
	import dss_pkg::*;

	logic [1:0] idx_next;

	// Gray-like order: 00->1, 10->2, 11->3, 01->4
	always_comb begin
		unique case ({sel_i.first, sel_i.second})
			2'b00: idx_next = 2'h0;
			2'b10: idx_next = 2'h1;
			2'b11: idx_next = 2'h2;
			2'b01: idx_next = 2'h3;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			idx_o <= `DSS_SEL_RESET;
		end else begin
			idx_o <= idx_next;
		end
	end
endmodule : dss_decode

/* File: design/dss_top.sv */
// Purpose: Start/stop, three-wire control and set selection of a drive
// Assumes: All control inputs except local_remote_i are pins asynchronous to ref_clk_i
// Notes:   Set and value indices 0..3 stand for choices 1..4
// Notes on behaviour
// - No acceleration unless a clockwise or anticlockwise start is active.
// - Three-wire enable level arms the drive; start pulse starts it.
// - Three-wire enable going low stops the drive.
// - Start latched while enable high; latch cleared when enable drops.
// - Start needs enable high plus rising edge of either start input.
// - While running in three-wire mode, further start edges are ignored.
// - Start pulse shorter than 32 ms shuts the drive down.
// - Both starts active within 32 ms of each other shut down.
// - Local/remote 5 gives three-wire mode from contacts only.
// - Local/remote 46 gives three-wire mode from contacts or keypad.
// - Two select bits pick parameter set 1 to 4 in Gray order.
// - Selected parameter set is reported as an actual value.
// - Two select bits pick fixed frequency 1 to 4 likewise.
// - Two select bits pick fixed percentage 1 to 4 likewise.
// - Digital input four feeds first set select with zero delay.
// - Speed or torque controller follows change-over, even while running.
// - Fault clears when acknowledgment signal is asserted. The code keeps the fault set while fault_i is still active.
`timescale 1ns/1ps
`include "dss_regs.svh"
module dss_top #(
	parameter int PULSE_MIN_CYC = `DSS_PULSE_MIN_CYC
) (
	input  wire logic              ref_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic [7:0]        local_remote_i,
	input  wire logic              start_cw_i,
	input  wire logic              start_ccw_i,
	input  wire logic              enable_3w_i,
	input  wire logic              keypad_unit_cw_i,
	input  wire logic              keypad_unit_ccw_i,
	input  wire logic              keypad_unit_en_i,
	input  wire logic              digital_input_four_i,
	input  wire logic              set_sel_two_i,
	input  wire dss_pkg::dss_sel_t freq_sel_i,
	input  wire dss_pkg::dss_sel_t pct_sel_i,
	input  wire logic              torque_mode_i,
	input  wire logic              fault_i,
	input  wire logic              fault_ack_i,
	output dss_pkg::dss_drive_t    drive_o,
	output logic                   three_wire_o,
	output logic [1:0]             param_set_o,
	output logic [1:0]             fixed_freq_o,
	output logic [1:0]             fixed_pct_o,
	output logic                   torque_ctrl_o,
	output logic                   fault_o
);
	import dss_pkg::*;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	localparam int CW = $clog2(PULSE_MIN_CYC + 1);

	logic [12:0]   raw_in;
	logic [12:0]   syn;
	logic          s_cw;
	logic          s_ccw;
	logic          s_en;
	logic          k_cw;
	logic          k_ccw;
	logic          k_en;
	logic          s_di4;
	logic          s_ds2;
	logic          s_torq;
	logic          s_fault;
	logic          s_ack;
	dss_sel_t      s_freq;
	dss_sel_t      s_pct;
	dss_sel_t      set_sel;
	logic          mode_3w;
	logic          cw_in;
	logic          ccw_in;
	logic          en_in;
	logic          cw_d_reg;
	logic          ccw_d_reg;
	logic          cw_rise;
	logic          ccw_rise;
	dss_state_t    state_reg;
	logic          dir_cw_reg;
	logic [CW-1:0] cnt_reg;
	logic          other_reg;
	logic          bad_pulse;

	assign raw_in = {start_cw_i, start_ccw_i, enable_3w_i, keypad_unit_cw_i,
		keypad_unit_ccw_i, keypad_unit_en_i, digital_input_four_i,
		set_sel_two_i, torque_mode_i, fault_i, fault_ack_i,
		freq_sel_i.first, freq_sel_i.second};

	dss_sync #(.W(13)) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.d_i       (raw_in),
		.q_o       (syn)
	);

	dss_sync #(.W(2)) u_sync_pct (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.d_i       ({pct_sel_i.first, pct_sel_i.second}),
		.q_o       ({s_pct.first, s_pct.second})
	);

	assign {s_cw, s_ccw, s_en, k_cw, k_ccw, k_en, s_di4, s_ds2, s_torq,
		s_fault, s_ack, s_freq.first, s_freq.second} = syn;

	// Timer in default setting has zero delay: input passes straight on
	assign set_sel.first  = s_di4;
	assign set_sel.second = s_ds2;

	dss_decode u_dec_set (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.sel_i     (set_sel),
		.idx_o     (param_set_o)
	);

	dss_decode u_dec_freq (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.sel_i     (s_freq),
		.idx_o     (fixed_freq_o)
	);

	dss_decode u_dec_pct (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.sel_i     (s_pct),
		.idx_o     (fixed_pct_o)
	);

	// Mode selection and source merge
	always_comb begin
		mode_3w = 1'b0;
		cw_in   = s_cw;
		ccw_in  = s_ccw;
		en_in   = s_en;
		if (local_remote_i == `DSS_LR_3W_CONTACT) begin
			mode_3w = 1'b1;
		end else if (local_remote_i == `DSS_LR_3W_KEYPAD) begin
			mode_3w = 1'b1;
			cw_in   = s_cw | k_cw;
			ccw_in  = s_ccw | k_ccw;
			en_in   = s_en | k_en;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cw_d_reg  <= 1'b0;
			ccw_d_reg <= 1'b0;
		end else begin
			cw_d_reg  <= cw_in;
			ccw_d_reg <= ccw_in;
		end
	end

	assign cw_rise  = cw_in & ~cw_d_reg;
	assign ccw_rise = ccw_in & ~ccw_d_reg;

	// Pulse ends early, or the other input rises, inside the check window
	assign bad_pulse = (dir_cw_reg ? !cw_in : !ccw_in)
		| (dir_cw_reg ? ccw_rise : cw_rise) | other_reg;

	// Three-wire start state machine
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg  <= DSS_IDLE;
			dir_cw_reg <= 1'b1;
			cnt_reg    <= '0;
			other_reg  <= 1'b0;
		end else if (!mode_3w || !en_in || s_fault || fault_o) begin
			state_reg <= DSS_IDLE;
			cnt_reg   <= '0;
			other_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				DSS_IDLE: begin
					if (cw_rise || ccw_rise) begin
						state_reg  <= DSS_CHECK;
						dir_cw_reg <= cw_rise;
						other_reg  <= cw_rise & ccw_rise;
						cnt_reg    <= '0;
					end
				end
				DSS_CHECK: begin
					if (bad_pulse) begin
						state_reg <= DSS_IDLE;
						other_reg <= 1'b0;
					end else if (cnt_reg == CW'(PULSE_MIN_CYC - 1)) begin
						state_reg <= DSS_RUN;
					end else begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				DSS_RUN: begin
					state_reg <= DSS_RUN;
				end
			endcase
		end
	end

	// Drive command: three-wire start runs from the first edge, latched once the check window has passed
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			drive_o <= '{run_cw: 1'b0, run_ccw: 1'b0, stop: 1'b1};
		end else if (fault_o || s_fault) begin
			drive_o <= '{run_cw: 1'b0, run_ccw: 1'b0, stop: 1'b1};
		end else if (mode_3w) begin
			drive_o.run_cw  <= (state_reg != DSS_IDLE) & dir_cw_reg
				& en_in & !(state_reg == DSS_CHECK && bad_pulse);
			drive_o.run_ccw <= (state_reg != DSS_IDLE) & !dir_cw_reg
				& en_in & !(state_reg == DSS_CHECK && bad_pulse);
			drive_o.stop    <= (state_reg == DSS_IDLE) | !en_in
				| (state_reg == DSS_CHECK && bad_pulse);
		end else begin
			// Level start; both at once is not a valid command
			drive_o.run_cw  <= s_cw & !s_ccw;
			drive_o.run_ccw <= s_ccw & !s_cw;
			drive_o.stop    <= !(s_cw ^ s_ccw);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			three_wire_o <= 1'b0;
		end else begin
			three_wire_o <= mode_3w;
		end
	end

	// Change-over honoured in any state, running or not
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			torque_ctrl_o <= 1'b0;
		end else begin
			torque_ctrl_o <= s_torq;
		end
	end

	// Fault set wins over acknowledge
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fault_o <= 1'b0;
		end else if (s_fault) begin
			fault_o <= 1'b1;
		end else if (s_ack) begin
			fault_o <= 1'b0;
		end
	end

	a_no_run_idle: assert property (
		(mode_3w && !en_in) |=> !drive_o.run_cw && !drive_o.run_ccw)
		else $error("drive runs without three-wire enable");
	a_run_excl: assert property (
		!(drive_o.run_cw && drive_o.run_ccw)
		&& (drive_o.stop != (drive_o.run_cw || drive_o.run_ccw)))
		else $error("drive command inconsistent");
	a_level_start: assert property (
		(!mode_3w && !s_fault && !fault_o && s_cw && !s_ccw)
		|=> drive_o.run_cw && !drive_o.stop)
		else $error("level start not followed");
	a_start_edge: assert property (
		$rose(state_reg == DSS_CHECK) |-> $past(mode_3w) && $past(en_in)
		&& ($past(cw_rise) || $past(ccw_rise)))
		else $error("start without enable and rising edge");
	a_run_hold: assert property (
		(state_reg == DSS_RUN && mode_3w && en_in && !s_fault && !fault_o)
		|=> state_reg == DSS_RUN)
		else $error("running state left without cause");
	a_short_pulse: assert property (
		(state_reg == DSS_CHECK && bad_pulse && !fault_o) |=> ##1
		drive_o.stop)
		else $error("short pulse did not stop drive");
	a_both_start: assert property (
		(state_reg == DSS_CHECK && (dir_cw_reg ? ccw_rise : cw_rise))
		|=> state_reg == DSS_IDLE)
		else $error("second start inside window did not stop");
	a_check_len: assert property (
		$rose(state_reg == DSS_RUN)
		|-> $past(cnt_reg) == CW'(PULSE_MIN_CYC - 1))
		else $error("check window length wrong");
	a_ack_clear: assert property (
		(fault_o && s_ack && !s_fault) |=> !fault_o)
		else $error("fault not acknowledged");
	a_fault_set: assert property (
		s_fault |=> fault_o && drive_o.stop)
		else $error("fault did not stop drive");
	a_torque_follow: assert property (
		##1 torque_ctrl_o == $past(s_torq))
		else $error("change-over not followed");
	a_set_code: assert property (
		(set_sel.first && set_sel.second) |=> param_set_o == 2'h2)
		else $error("set select code wrong");
	a_freq_code: assert property (
		(s_freq.first && !s_freq.second) |=> fixed_freq_o == 2'h1)
		else $error("frequency select code wrong");
	a_pct_code: assert property (
		(!s_pct.first && s_pct.second) |=> fixed_pct_o == 2'h3)
		else $error("percentage select code wrong");
	a_mode_sel: assert property (
		##1 three_wire_o == ($past(local_remote_i) == `DSS_LR_3W_CONTACT
		|| $past(local_remote_i) == `DSS_LR_3W_KEYPAD))
		else $error("three-wire mode wrong");
	a_keypad_start: assert property (
		(local_remote_i == `DSS_LR_3W_KEYPAD && state_reg == DSS_IDLE
		&& k_en && k_cw && !cw_d_reg && !s_fault && !fault_o)
		|=> state_reg == DSS_CHECK)
		else $error("keypad start not taken");
endmodule : dss_top

/* File: verification/dss_contacts.sv */
// Purpose: Model of the control contacts and keypad unit facing the block
// Assumes: Pins change only at the falling clock edge
// Notes:   Pulse length is chosen per call, short or long
`timescale 1ns/1ps
module dss_contacts (
	input  wire logic ref_clk_i,
	output logic      start_cw_o,
	output logic      start_ccw_o,
	output logic      enable_3w_o,
	output logic      keypad_unit_cw_o,
	output logic      keypad_unit_ccw_o,
	output logic      keypad_unit_en_o
);
	logic [5:0] pins = 6'h00;

	assign {keypad_unit_en_o, keypad_unit_ccw_o, keypad_unit_cw_o,
		enable_3w_o, start_ccw_o, start_cw_o} = pins;

	task set_pins(input logic [5:0] mask, input logic val);
		@(negedge ref_clk_i);
		pins = val ? (pins | mask) : (pins & ~mask);
	endtask : set_pins

	// Contacts closed for len cycles, then opened
	task pulse(input logic [5:0] mask, input int len);
		set_pins(mask, 1'b1);
		repeat (len - 1) @(negedge ref_clk_i);
		set_pins(mask, 1'b0);
	endtask : pulse
endmodule : dss_contacts

/* File: verification/dss_top_tb_top.sv */
// Purpose: Self-checking bench for drive start and set select
// Assumes: Short check window parameter for a brief run
// Notes:   Expected results queue up and are compared by a watcher
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
	end end
module dss_top_tb_top;
	import dss_pkg::*;
	localparam int         PMIN  = 20;
	localparam logic [5:0] M_CW  = 6'h01;
	localparam logic [5:0] M_CCW = 6'h02;
	localparam logic [5:0] M_EN  = 6'h04;
	localparam logic [5:0] M_KCW = 6'h08;
	localparam logic [5:0] M_KCCW = 6'h10;
	localparam logic [5:0] M_KEN = 6'h20;
	localparam dss_drive_t STOP  = 3'h1;
	localparam dss_drive_t RCW   = 3'h4;
	localparam dss_drive_t RCCW  = 3'h2;
	logic        ref_clk_i = 1'b0;
	logic        rst_b_i   = 1'b0;
	logic [7:0]  local_remote_i = 8'h00;
	logic        dif4 = 1'b0, s2 = 1'b0, tq = 1'b0, flt = 1'b0, ack = 1'b0;
	dss_sel_t    fq = '0, pc = '0;
	logic        cw, ccw, en, kcw, kccw, ken, tw, tqo, flo;
	dss_drive_t  drv;
	logic [1:0]  pso, ffo, fpo;
	logic [11:0] exp_q[$];
	event        sample_ev;
	int          n_fail = 0, n_compared = 0;
	logic [31:0] rnd = 32'h78B1;

	always #2.5 ref_clk_i = ~ref_clk_i;

	dss_contacts far (.ref_clk_i(ref_clk_i), .start_cw_o(cw),
		.start_ccw_o(ccw), .enable_3w_o(en), .keypad_unit_cw_o(kcw),
		.keypad_unit_ccw_o(kccw), .keypad_unit_en_o(ken));

	dss_top #(.PULSE_MIN_CYC(PMIN)) dut (.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i), .local_remote_i(local_remote_i),
		.start_cw_i(cw), .start_ccw_i(ccw), .enable_3w_i(en),
		.keypad_unit_cw_i(kcw), .keypad_unit_ccw_i(kccw),
		.keypad_unit_en_i(ken), .digital_input_four_i(dif4),
		.set_sel_two_i(s2), .freq_sel_i(fq), .pct_sel_i(pc),
		.torque_mode_i(tq), .fault_i(flt), .fault_ack_i(ack),
		.drive_o(drv), .three_wire_o(tw), .param_set_o(pso),
		.fixed_freq_o(ffo), .fixed_pct_o(fpo), .torque_ctrl_o(tqo),
		.fault_o(flo));

	function automatic logic [1:0] gray(input logic f, input logic s);
		case ({f, s})
			2'b00: return 2'h0;
			2'b10: return 2'h1;
			2'b11: return 2'h2;
			default: return 2'h3;
		endcase
	endfunction : gray

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction : lfsr

	// Let the synchroniser and output stage settle, then note the result
	task note(input dss_drive_t d, input logic t3, input logic fo);
		repeat (6) @(negedge ref_clk_i);
		exp_q.push_back({d, t3, gray(dif4, s2), gray(fq.first, fq.second),
			gray(pc.first, pc.second), tq, fo});
		-> sample_ev;
	endtask : note

	always @(sample_ev) begin : watch
		logic [11:0] e;
		e = exp_q.pop_front();
		`CHK({drv, tw, pso, ffo, fpo, tqo, flo}, e)
	end

	task wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	initial begin : watchdog
		#20000;
		n_fail++;
		wrap_up();
	end

	initial begin : main
		note(STOP, 1'b0, 1'b0);
		repeat (6) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			{dif4, s2} = i[1:0];
			fq = i[3:2];
			pc = i[1:0] ^ i[3:2];
			tq = rnd[0];
			note(STOP, 1'b0, 1'b0);
		end
		note(STOP, 1'b0, 1'b0);
		local_remote_i = 8'h05;
		far.pulse(M_CW, 30);
		note(STOP, 1'b1, 1'b0);
		far.set_pins(M_EN, 1'b1);
		note(STOP, 1'b1, 1'b0);
		far.set_pins(M_CW, 1'b1);
		note(RCW, 1'b1, 1'b0);
		repeat (PMIN) @(negedge ref_clk_i);
		far.set_pins(M_CW, 1'b0);
		note(RCW, 1'b1, 1'b0);
		far.pulse(M_CCW, 30);
		tq = ~tq;
		note(RCW, 1'b1, 1'b0);
		far.set_pins(M_EN, 1'b0);
		note(STOP, 1'b1, 1'b0);
		far.set_pins(M_CW, 1'b1);
		far.set_pins(M_EN, 1'b1);
		note(STOP, 1'b1, 1'b0);
		far.set_pins(M_CW, 1'b0);
		far.pulse(M_CW, 5);
		note(STOP, 1'b1, 1'b0);
		far.set_pins(M_CW, 1'b1);
		repeat (4) @(negedge ref_clk_i);
		far.set_pins(M_CCW, 1'b1);
		repeat (PMIN) @(negedge ref_clk_i);
		note(STOP, 1'b1, 1'b0);
		far.set_pins(M_CW | M_CCW, 1'b0);
		far.set_pins(M_EN, 1'b0);
		far.set_pins(M_KEN, 1'b1);
		far.pulse(M_KCW, 30);
		note(STOP, 1'b1, 1'b0);
		local_remote_i = 8'h2E;
		far.pulse(M_KCW, 30);
		note(RCW, 1'b1, 1'b0);
		far.set_pins(M_KEN, 1'b0);
		note(STOP, 1'b1, 1'b0);
		far.set_pins(M_KEN, 1'b1);
		far.pulse(M_KCCW, 30);
		note(RCCW, 1'b1, 1'b0);
		far.set_pins(M_KEN, 1'b0);
		local_remote_i = 8'h00;
		far.set_pins(M_CW, 1'b1);
		note(RCW, 1'b0, 1'b0);
		far.set_pins(M_CCW, 1'b1);
		note(STOP, 1'b0, 1'b0);
		far.set_pins(M_CCW, 1'b0);
		note(RCW, 1'b0, 1'b0);
		far.set_pins(M_CW, 1'b0);
		far.set_pins(M_CCW, 1'b1);
		note(RCCW, 1'b0, 1'b0);
		flt = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		flt = 1'b0;
		note(STOP, 1'b0, 1'b1);
		far.set_pins(M_CCW, 1'b0);
		ack = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		ack = 1'b0;
		note(STOP, 1'b0, 1'b0);
		// Let the watcher take the last note before the verdict
		@(negedge ref_clk_i);
		wrap_up();
	end
endmodule : dss_top_tb_top
